// ==== rtl/usc_pkg.sv ====
// Constants, modes and carriers of the serial port control block
package usc_pkg;

    localparam int AXI_AW = 12;

    // Word indices; byte address is four times the index
    localparam logic [9:0] IDX_STATUS_A = 10'h0C0;
    localparam logic [9:0] IDX_CTRL_B   = 10'h0C1;
    localparam logic [9:0] IDX_CTRL_C   = 10'h0C2;

    localparam logic [7:0] RST_STATUS_A = 8'h20;
    localparam logic [7:0] RST_CTRL_B   = 8'h00;
    localparam logic [7:0] RST_CTRL_C   = 8'h06;

    localparam int A_RX_DONE   = 7;
    localparam int A_TX_DONE   = 6;
    localparam int A_BUF_EMPTY = 5;
    localparam int A_FRAME_ERR = 4;
    localparam int A_OVERRUN   = 3;
    localparam int A_PAR_ERR   = 2;
    localparam int A_DOUBLE    = 1;
    localparam int A_MULTI     = 0;

    localparam int B_RX_IRQ    = 7;
    localparam int B_TX_IRQ    = 6;
    localparam int B_EMPTY_IRQ = 5;
    localparam int B_RX_EN     = 4;
    localparam int B_TX_EN     = 3;
    localparam int B_SIZE_HI   = 2;
    localparam int B_RX_NINTH  = 1;
    localparam int B_TX_NINTH  = 0;

    localparam int C_MODE_HI   = 7;
    localparam int C_MODE_LO   = 6;
    localparam int C_PAR_HI    = 5;
    localparam int C_PAR_LO    = 4;
    localparam int C_STOP      = 3;
    localparam int C_SIZE_MID  = 2;
    localparam int C_SIZE_LOW  = 1;
    localparam int C_POLARITY  = 0;

    localparam logic [4:0] DIV_NORMAL = 5'h10;
    localparam logic [4:0] DIV_DOUBLE = 5'h08;
    localparam logic [4:0] DIV_SYNC   = 5'h02;

    localparam logic [3:0] BITS_FIVE  = 4'h5;
    localparam logic [3:0] BITS_SIX   = 4'h6;
    localparam logic [3:0] BITS_SEVEN = 4'h7;
    localparam logic [3:0] BITS_EIGHT = 4'h8;
    localparam logic [3:0] BITS_NINE  = 4'h9;

    localparam logic [2:0] SIZE_NINE  = 3'h7;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        MODE_ASYNC = 2'h0,
        MODE_SYNC  = 2'h1,
        MODE_RSVD  = 2'h2,
        MODE_SPI   = 2'h3
    } usc_mode_e;

    typedef enum logic [1:0] {
        TX_OFF   = 2'h0,
        TX_ON    = 2'h1,
        TX_DRAIN = 2'h3
    } usc_tx_e;

    typedef struct packed {
        logic              awvalid;
        logic [AXI_AW-1:0] awaddr;
        logic              wvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [AXI_AW-1:0] araddr;
        logic              rready;
    } usc_axi_req_s;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } usc_axi_rsp_s;

    typedef struct packed {
        logic rxFrameDone;
        logic rxNinthBit;
        logic rxFrameErr;
        logic rxOverrun;
        logic rxParityErr;
        logic rxUnread;
        logic txShiftDone;
        logic txBufEmpty;
        logic txPending;
    } usc_eng_s;

    typedef struct packed {
        logic [4:0] baudDivisor;
        logic [3:0] dataBits;
        logic       parityEn;
        logic       parityOdd;
        logic       twoStopBits;
        usc_mode_e  opMode;
        logic       lsbFirst;
        logic       sampleOnRise;
        logic       shiftOnRise;
        logic       clkIdleHigh;
        logic       txNinthBit;
        logic       dropDataFrames;
        logic       rxPinOwn;
        logic       txPinOwn;
        logic       rxFlush;
    } usc_cfg_s;

    typedef struct packed {
        logic rxDoneIrq;
        logic txDoneIrq;
        logic bufferEmptyIrq;
    } usc_irq_s;

endpackage

// ==== rtl/usc_control_config.sv ====
// Serial port control and configuration registers over AXI4-Lite
`timescale 1ns/1ns
module usc_control_config
    import usc_pkg::*;
(
    input  wire          clk,
    input  wire          sys_rst,
    input  usc_axi_req_s axiReq,
    output usc_axi_rsp_s axiRsp,
    input  usc_eng_s     engIn,
    input  wire          globalIrqEnable,
    output usc_cfg_s     cfgOut,
    output usc_irq_s     irqOut
);

    logic       awreadyReg;
    logic       awready_next;
    logic       wreadyReg;
    logic       wready_next;
    logic       awHeldReg;
    logic       awHeld_next;
    logic       wHeldReg;
    logic       wHeld_next;
    logic [9:0] awIdxReg;
    logic [9:0] awIdx_next;
    logic [7:0] wByteReg;
    logic [7:0] wByte_next;
    logic       wLaneReg;
    logic       wLane_next;
    logic       bvalidReg;
    logic       bvalid_next;
    logic [1:0] brespReg;
    logic [1:0] bresp_next;
    logic       arreadyReg;
    logic       arready_next;
    logic       rvalidReg;
    logic       rvalid_next;
    logic [7:0] rdataReg;
    logic [7:0] rdata_next;
    logic [1:0] rrespReg;
    logic [1:0] rresp_next;
    logic       awHs;
    logic       wHs;
    logic       arHs;
    logic       wrFire;
    logic       wrA;
    logic       wrB;
    logic       wrC;

    logic       txDoneReg;
    logic       txDone_next;
    logic       frameErrReg;
    logic       frameErr_next;
    logic       overrunReg;
    logic       overrun_next;
    logic       parErrReg;
    logic       parErr_next;
    logic       doubleReg;
    logic       double_next;
    logic       multiReg;
    logic       multi_next;
    logic       rxNinthReg;
    logic       rxNinth_next;
    logic [7:0] ctrlBReg;
    logic [7:0] ctrlB_next;
    logic [7:0] ctrlCReg;
    logic [7:0] ctrlC_next;
    usc_tx_e    txStateReg;
    usc_tx_e    txState_next;
    usc_cfg_s   cfgReg;
    usc_cfg_s   cfg_next;
    usc_irq_s   irqReg;
    usc_irq_s   irq_next;

    usc_mode_e  mode;
    logic       spi;
    logic       sync;
    logic       async;
    logic [2:0] sizeCode;
    logic       nineBits;
    logic       rxDoneFlag;
    logic [7:0] statusA;

    assign mode = usc_mode_e'(ctrlCReg[C_MODE_HI:C_MODE_LO]);
    assign spi = (mode == MODE_SPI);
    assign sync = (mode == MODE_SYNC);
    assign async = !spi && !sync; // Reserved mode runs async
    assign sizeCode = {ctrlBReg[B_SIZE_HI], ctrlCReg[C_SIZE_MID:C_SIZE_LOW]};
    assign nineBits = !spi && (sizeCode == SIZE_NINE);
    assign rxDoneFlag = engIn.rxUnread && ctrlBReg[B_RX_EN];
    assign statusA = {rxDoneFlag, txDoneReg, engIn.txBufEmpty,
                      frameErrReg, overrunReg, parErrReg,
                      doubleReg, multiReg};

    assign axiRsp.awready = awreadyReg;
    assign axiRsp.wready = wreadyReg;
    assign axiRsp.bvalid = bvalidReg;
    assign axiRsp.bresp = brespReg;
    assign axiRsp.arready = arreadyReg;
    assign axiRsp.rvalid = rvalidReg;
    assign axiRsp.rdata = {24'h00_0000, rdataReg};
    assign axiRsp.rresp = rrespReg;
    assign cfgOut = cfgReg;
    assign irqOut = irqReg;

    // Bus slave: one write and one read under way at a time
    always_comb begin
        awHs = axiReq.awvalid && awreadyReg;
        wHs = axiReq.wvalid && wreadyReg;
        awIdx_next = awHs ? axiReq.awaddr[AXI_AW-1:2] : awIdxReg;
        wByte_next = wHs ? axiReq.wdata[7:0] : wByteReg;
        wLane_next = wHs ? axiReq.wstrb[0] : wLaneReg;
        awHeld_next = awHeldReg || awHs;
        wHeld_next = wHeldReg || wHs;
        bvalid_next = bvalidReg && !axiReq.bready;
        bresp_next = brespReg;
        wrFire = awHeld_next && wHeld_next && !bvalidReg;
        wrA = 1'b0;
        wrB = 1'b0;
        wrC = 1'b0;
        if (wrFire) begin
            awHeld_next = 1'b0;
            wHeld_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = RESP_OKAY;
            case (awIdx_next)
                IDX_STATUS_A: wrA = wLane_next;
                IDX_CTRL_B:   wrB = wLane_next;
                IDX_CTRL_C:   wrC = wLane_next;
                default:      bresp_next = RESP_SLVERR;
            endcase
        end
        awready_next = !awHeld_next && !bvalid_next;
        wready_next = !wHeld_next && !bvalid_next;

        arHs = axiReq.arvalid && arreadyReg;
        rvalid_next = rvalidReg && !axiReq.rready;
        arready_next = !arHs && !(rvalidReg && !axiReq.rready);
        rdata_next = rdataReg;
        rresp_next = rrespReg;
        if (arHs) begin
            rvalid_next = 1'b1;
            rresp_next = RESP_OKAY;
            case (axiReq.araddr[AXI_AW-1:2])
                IDX_STATUS_A: rdata_next = statusA;
                IDX_CTRL_B: begin
                    rdata_next = ctrlBReg;
                    rdata_next[B_RX_NINTH] = rxNinthReg;
                end
                IDX_CTRL_C:   rdata_next = ctrlCReg;
                default: begin
                    rdata_next = 8'h00;
                    rresp_next = RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            awreadyReg <= 1'b0;
            wreadyReg <= 1'b0;
            awHeldReg <= 1'b0;
            wHeldReg <= 1'b0;
            awIdxReg <= 10'h000;
            wByteReg <= 8'h00;
            wLaneReg <= 1'b0;
            bvalidReg <= 1'b0;
            brespReg <= RESP_OKAY;
            arreadyReg <= 1'b0;
            rvalidReg <= 1'b0;
            rdataReg <= 8'h00;
            rrespReg <= RESP_OKAY;
        end else begin
            awreadyReg <= awready_next;
            wreadyReg <= wready_next;
            awHeldReg <= awHeld_next;
            wHeldReg <= wHeld_next;
            awIdxReg <= awIdx_next;
            wByteReg <= wByte_next;
            wLaneReg <= wLane_next;
            bvalidReg <= bvalid_next;
            brespReg <= bresp_next;
            arreadyReg <= arready_next;
            rvalidReg <= rvalid_next;
            rdataReg <= rdata_next;
            rrespReg <= rresp_next;
        end
    end

    // Control state, flags and configuration decode
    always_comb begin
        // Set wins over the write-one clear
        txDone_next = engIn.txShiftDone
                    || (txDoneReg && !(wrA && wByte_next[A_TX_DONE]));
        double_next = wrA ? wByte_next[A_DOUBLE] : doubleReg;
        multi_next = wrA ? wByte_next[A_MULTI] : multiReg;
        ctrlB_next = wrB ? wByte_next : ctrlBReg;
        ctrlB_next[B_RX_NINTH] = 1'b0;
        ctrlC_next = wrC ? wByte_next : ctrlCReg;

        frameErr_next = frameErrReg;
        overrun_next = overrunReg;
        parErr_next = parErrReg;
        rxNinth_next = rxNinthReg;
        if (!ctrlBReg[B_RX_EN]) begin
            frameErr_next = 1'b0;
            overrun_next = 1'b0;
            parErr_next = 1'b0;
            rxNinth_next = 1'b0;
        end else if (engIn.rxFrameDone) begin
            frameErr_next = !spi && engIn.rxFrameErr;
            overrun_next = !spi && engIn.rxOverrun;
            parErr_next = cfgReg.parityEn && engIn.rxParityErr;
            rxNinth_next = nineBits && engIn.rxNinthBit;
        end

        // Transmitter releases its pin only once drained
        txState_next = txStateReg;
        case (txStateReg)
            TX_OFF: begin
                if (ctrlBReg[B_TX_EN]) txState_next = TX_ON;
            end
            TX_ON: begin
                if (!ctrlBReg[B_TX_EN]) begin
                    txState_next = engIn.txPending ? TX_DRAIN : TX_OFF;
                end
            end
            TX_DRAIN: begin
                if (ctrlBReg[B_TX_EN]) txState_next = TX_ON;
                else if (!engIn.txPending) txState_next = TX_OFF;
            end
            default: txState_next = TX_OFF;
        endcase

        cfg_next.opMode = mode;
        if (!async) cfg_next.baudDivisor = DIV_SYNC;
        else if (doubleReg) cfg_next.baudDivisor = DIV_DOUBLE;
        else cfg_next.baudDivisor = DIV_NORMAL;
        case (sizeCode)
            3'h0:    cfg_next.dataBits = BITS_FIVE;
            3'h1:    cfg_next.dataBits = BITS_SIX;
            3'h2:    cfg_next.dataBits = BITS_SEVEN;
            3'h3:    cfg_next.dataBits = BITS_EIGHT;
            3'h7:    cfg_next.dataBits = BITS_NINE;
            default: cfg_next.dataBits = BITS_EIGHT;
        endcase
        if (spi) cfg_next.dataBits = BITS_EIGHT;
        cfg_next.parityEn = !spi && ctrlCReg[C_PAR_HI];
        cfg_next.parityOdd = ctrlCReg[C_PAR_LO];
        cfg_next.twoStopBits = !spi && ctrlCReg[C_STOP];
        cfg_next.lsbFirst = spi && ctrlCReg[C_SIZE_MID];
        if (spi) begin
            cfg_next.sampleOnRise = !(ctrlCReg[C_SIZE_LOW]
                                    ^ ctrlCReg[C_POLARITY]);
        end else begin
            cfg_next.sampleOnRise = sync && ctrlCReg[C_POLARITY];
        end
        cfg_next.shiftOnRise = !async && !cfg_next.sampleOnRise;
        cfg_next.clkIdleHigh = !async && ctrlCReg[C_POLARITY];
        cfg_next.txNinthBit = nineBits && ctrlBReg[B_TX_NINTH];
        cfg_next.dropDataFrames = !spi && multiReg;
        cfg_next.rxPinOwn = ctrlBReg[B_RX_EN];
        cfg_next.txPinOwn = (txState_next != TX_OFF);
        cfg_next.rxFlush = ctrlBReg[B_RX_EN] && !ctrlB_next[B_RX_EN];

        irq_next.rxDoneIrq = ctrlBReg[B_RX_IRQ] && globalIrqEnable
                           && rxDoneFlag;
        irq_next.txDoneIrq = ctrlBReg[B_TX_IRQ] && globalIrqEnable
                           && txDoneReg;
        irq_next.bufferEmptyIrq = ctrlBReg[B_EMPTY_IRQ] && globalIrqEnable
                                && engIn.txBufEmpty;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            txDoneReg <= RST_STATUS_A[A_TX_DONE];
            frameErrReg <= RST_STATUS_A[A_FRAME_ERR];
            overrunReg <= RST_STATUS_A[A_OVERRUN];
            parErrReg <= RST_STATUS_A[A_PAR_ERR];
            doubleReg <= RST_STATUS_A[A_DOUBLE];
            multiReg <= RST_STATUS_A[A_MULTI];
            rxNinthReg <= 1'b0;
            ctrlBReg <= RST_CTRL_B;
            ctrlCReg <= RST_CTRL_C;
            txStateReg <= TX_OFF;
            cfgReg <= '0;
            irqReg <= '0;
        end else begin
            txDoneReg <= txDone_next;
            frameErrReg <= frameErr_next;
            overrunReg <= overrun_next;
            parErrReg <= parErr_next;
            doubleReg <= double_next;
            multiReg <= multi_next;
            rxNinthReg <= rxNinth_next;
            ctrlBReg <= ctrlB_next;
            ctrlCReg <= ctrlC_next;
            txStateReg <= txState_next;
            cfgReg <= cfg_next;
            irqReg <= irq_next;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_div_double;
        (async && doubleReg) |=> cfgReg.baudDivisor == DIV_DOUBLE;
    endproperty
    a_div_double: assert property (p_div_double)
        else $error("async double speed divisor not 8");
    property p_div_sync;
        (!async && doubleReg) |=> cfgReg.baudDivisor == DIV_SYNC;
    endproperty
    a_div_sync: assert property (p_div_sync)
        else $error("double speed acted outside async");
    property p_drop;
        (multiReg && !spi) |=> cfgReg.dropDataFrames;
    endproperty
    a_drop: assert property (p_drop)
        else $error("multiprocessor drop not raised");
    property p_rx_irq;
        irqReg.rxDoneIrq |-> $past(ctrlBReg[B_RX_IRQ] && globalIrqEnable
                                   && rxDoneFlag);
    endproperty
    a_rx_irq: assert property (p_rx_irq)
        else $error("receive irq without its cause");
    property p_tx_irq;
        (ctrlBReg[B_TX_IRQ] && globalIrqEnable && txDoneReg)
            |=> irqReg.txDoneIrq;
    endproperty
    a_tx_irq: assert property (p_tx_irq)
        else $error("transmit irq missing");
    property p_empty_irq;
        !globalIrqEnable |=> !irqReg.bufferEmptyIrq;
    endproperty
    a_empty_irq: assert property (p_empty_irq)
        else $error("empty irq while globally masked");
    property p_rx_flush;
        $fell(ctrlBReg[B_RX_EN]) |-> cfgReg.rxFlush
            ##1 (!frameErrReg && !overrunReg && !parErrReg);
    endproperty
    a_rx_flush: assert property (p_rx_flush)
        else $error("receiver disable did not flush");
    property p_tx_hold;
        (txStateReg == TX_DRAIN && engIn.txPending) |=> cfgReg.txPinOwn;
    endproperty
    a_tx_hold: assert property (p_tx_hold)
        else $error("transmit pin released while pending");
    property p_size_nine;
        (!spi && sizeCode == SIZE_NINE) |=> cfgReg.dataBits == BITS_NINE;
    endproperty
    a_size_nine: assert property (p_size_nine)
        else $error("nine bit size not decoded");
    property p_spi_frame;
        spi |=> (cfgReg.dataBits == BITS_EIGHT) && !cfgReg.parityEn
                && !cfgReg.twoStopBits;
    endproperty
    a_spi_frame: assert property (p_spi_frame)
        else $error("SPI frame format not fixed");
    property p_edges;
        !async |=> cfgReg.sampleOnRise != cfgReg.shiftOnRise;
    endproperty
    a_edges: assert property (p_edges)
        else $error("shift and sample on same edge");

    c_spi: cover property (spi ##1 cfgReg.opMode == MODE_SPI);
    c_drain: cover property (txStateReg == TX_DRAIN ##1
                             txStateReg == TX_OFF);
    c_rx_irq: cover property (irqReg.rxDoneIrq);
    c_txc_clear: cover property (txDoneReg ##1 !txDoneReg);

endmodule

// ==== verif/usc_engine_model.sv ====
// Behavioural model of the transfer engine beside the control block
`timescale 1ns/1ns
module usc_engine_model
    import usc_pkg::*;
(
    input  wire       clk,
    input  wire       frameReq,
    input  wire       ninth,
    input  wire [2:0] errs,
    input  wire       unread,
    input  wire       shiftReq,
    input  wire       bufEmpty,
    input  wire       pending,
    output usc_eng_s  eng
);
    initial eng = '0;
    always @(posedge clk) begin
        eng.rxFrameDone <= frameReq;
        eng.txShiftDone <= shiftReq;
        eng.rxUnread    <= unread;
        eng.txBufEmpty  <= bufEmpty;
        eng.txPending   <= pending;
        // Frame status valid only with the done pulse, else toggling
        if (frameReq) begin
            eng.rxNinthBit  <= ninth;
            eng.rxFrameErr  <= errs[2];
            eng.rxOverrun   <= errs[1];
            eng.rxParityErr <= errs[0];
        end else begin
            eng.rxNinthBit  <= !eng.rxNinthBit;
            eng.rxFrameErr  <= !eng.rxFrameErr;
            eng.rxOverrun   <= !eng.rxOverrun;
            eng.rxParityErr <= !eng.rxParityErr;
        end
    end
endmodule

// ==== verif/usc_control_config_test.sv ====
// Register level testbench for the serial port control block
`timescale 1ns/1ns
module usc_control_config_test;
    import usc_pkg::*;
    localparam logic [11:0] AD_ST  = {IDX_STATUS_A, 2'b00};
    localparam logic [11:0] AD_B   = {IDX_CTRL_B, 2'b00};
    localparam logic [11:0] AD_C   = {IDX_CTRL_C, 2'b00};
    localparam logic [11:0] AD_BAD = 12'h0FC;
    logic         clk = 0;
    logic         sys_rst = 1;
    usc_axi_req_s axiReq = '0;
    usc_axi_rsp_s axiRsp;
    usc_eng_s     engIn;
    usc_cfg_s     cfgOut;
    usc_irq_s     irqOut;
    logic         gie = 0;
    logic         fReq = 0;
    logic         nin = 0;
    logic         unread = 0;
    logic         shReq = 0;
    logic         emp = 1;
    logic         pend = 0;
    logic [2:0]   errs = 0;
    logic [31:0]  rdat;
    logic [1:0]   resp;
    int           fails = 0;
    int           total_checks = 0;
    int           flushes = 0;

    always #20 clk = ~clk;
    always @(posedge clk) if (cfgOut.rxFlush === 1'b1) flushes++;

    usc_control_config i_usc_control_config (
        .clk(clk), .sys_rst(sys_rst), .axiReq(axiReq), .axiRsp(axiRsp),
        .engIn(engIn), .globalIrqEnable(gie), .cfgOut(cfgOut),
        .irqOut(irqOut));
    usc_engine_model i_usc_engine_model (
        .clk(clk), .frameReq(fReq), .ninth(nin), .errs(errs),
        .unread(unread), .shiftReq(shReq), .bufEmpty(emp),
        .pending(pend), .eng(engIn));

    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        axiReq.awvalid <= 1;
        axiReq.awaddr  <= a;
        axiReq.wvalid  <= 1;
        axiReq.wdata   <= {24'h0, d};
        axiReq.wstrb   <= 4'hF;
        axiReq.bready  <= 1;
        do begin
            @(posedge clk);
            if (axiReq.awvalid && axiRsp.awready) axiReq.awvalid <= 0;
            if (axiReq.wvalid && axiRsp.wready) axiReq.wvalid <= 0;
        end while (axiRsp.bvalid !== 1'b1);
        resp = axiRsp.bresp;
        axiReq.bready <= 0;
        #1;
    endtask

    task automatic rd(input logic [11:0] a);
        @(posedge clk);
        axiReq.arvalid <= 1;
        axiReq.araddr  <= a;
        axiReq.rready  <= 1;
        do begin
            @(posedge clk);
            if (axiReq.arvalid && axiRsp.arready) axiReq.arvalid <= 0;
        end while (axiRsp.rvalid !== 1'b1);
        rdat = axiRsp.rdata;
        resp = axiRsp.rresp;
        axiReq.rready <= 0;
        #1;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        end_sim();
    end

    initial begin
        logic [3:0] e;
        repeat (3) @(posedge clk);
        sys_rst <= 0;
        rd(AD_ST); chk("status", rdat, {24'h0, RST_STATUS_A});
        chk("rdResp", resp, RESP_OKAY);
        rd(AD_B); chk("ctrlB", rdat, {24'h0, RST_CTRL_B});
        rd(AD_C); chk("ctrlC", rdat, {24'h0, RST_CTRL_C});
        chk("divisor", cfgOut.baudDivisor, DIV_NORMAL);
        rd(AD_BAD); chk("badRdResp", resp, RESP_SLVERR);
        chk("badRdData", rdat, 0);
        wr(AD_BAD, 8'hFF); chk("badWrResp", resp, RESP_SLVERR);
        wr(AD_ST, 8'h02);
        chk("wrResp", resp, RESP_OKAY);
        chk("dblDiv", cfgOut.baudDivisor, DIV_DOUBLE);
        // Character size codes, high bit lives in control B
        for (int i = 0; i < 8; i++) begin
            wr(AD_B, {5'h0, i[2], 2'h0});
            wr(AD_C, {5'h0, i[1:0], 1'b0});
            e = (i == 7) ? BITS_NINE : i[2] ? BITS_EIGHT : BITS_FIVE + i[3:0];
            chk("dataBits", cfgOut.dataBits, e);
        end
        // Modes with double speed and nine bits still programmed
        for (int i = 0; i < 4; i++) begin
            wr(AD_C, {i[1:0], 6'h06});
            chk("opMode", cfgOut.opMode, i);
            chk("modeDiv", cfgOut.baudDivisor,
                i[0] ? DIV_SYNC : DIV_DOUBLE);
            chk("spiBits", cfgOut.dataBits,
                i == 3 ? BITS_EIGHT : BITS_NINE);
        end
        // Parity and stop bits, in async and in SPI
        for (int j = 0; j < 16; j++) begin
            wr(AD_C, {j[3], j[3], j[2:0], 3'h0});
            chk("parEn", cfgOut.parityEn, j[2] & !j[3]);
            if (j[2] & !j[3]) chk("parOdd", cfgOut.parityOdd, j[1]);
            chk("stops", cfgOut.twoStopBits, j[0] & !j[3]);
        end
        // SPI format bits taken in the mode-selecting write
        for (int i = 0; i < 8; i++) begin
            wr(AD_C, 8'h00);
            wr(AD_C, {5'h18, i[2:0]});
            chk("lsbFirst", cfgOut.lsbFirst, i[2]);
            chk("sample", cfgOut.sampleOnRise, !(i[1] ^ i[0]));
            chk("shift", cfgOut.shiftOnRise, i[1] ^ i[0]);
            chk("idle", cfgOut.clkIdleHigh, i[0]);
        end
        for (int i = 0; i < 2; i++) begin
            wr(AD_C, {7'h20, i[0]});
            chk("syncSample", cfgOut.sampleOnRise, i[0]);
            chk("syncShift", cfgOut.shiftOnRise, !i[0]);
        end
        wr(AD_B, 8'h05);
        wr(AD_C, 8'h06);
        wr(AD_ST, 8'h01);
        chk("txNinth", cfgOut.txNinthBit, 1);
        chk("dropFr", cfgOut.dropDataFrames, 1);
        wr(AD_C, 8'hC6);
        chk("spiNinth", cfgOut.txNinthBit, 0);
        chk("spiDrop", cfgOut.dropDataFrames, 0);
        // Receive path: capture, interrupt, then flush
        wr(AD_C, 8'h26);
        wr(AD_B, 8'h14); chk("rxOwn", cfgOut.rxPinOwn, 1);
        @(posedge clk);
        {fReq, nin, errs, unread} <= 6'h3F;
        @(posedge clk);
        fReq <= 0;
        repeat (3) @(posedge clk);
        rd(AD_ST); chk("rxErrs", rdat & 32'h1C, 32'h1C);
        rd(AD_B); chk("rxNinth", rdat, 32'h16);
        wr(AD_B, 8'h94);
        gie <= 1;
        repeat (3) @(posedge clk);
        chk("rxIrq", irqOut.rxDoneIrq, 1);
        gie <= 0;
        repeat (3) @(posedge clk);
        chk("rxIrqGie", irqOut.rxDoneIrq, 0);
        wr(AD_B, 8'h04);
        repeat (2) @(posedge clk);
        chk("flush", flushes, 1);
        chk("rxOff", cfgOut.rxPinOwn, 0);
        rd(AD_ST); chk("errsGone", rdat & 32'h1C, 0);
        // Data register empty interrupt
        gie <= 1;
        wr(AD_B, 8'h20);
        repeat (3) @(posedge clk);
        chk("emptyIrq", irqOut.bufferEmptyIrq, 1);
        emp <= 0;
        repeat (3) @(posedge clk);
        chk("emptyIrqOff", irqOut.bufferEmptyIrq, 0);
        // Transmit done, clear, and delayed disable
        wr(AD_B, 8'h48); chk("txOwn", cfgOut.txPinOwn, 1);
        shReq <= 1;
        @(posedge clk);
        shReq <= 0;
        repeat (3) @(posedge clk);
        chk("txIrq", irqOut.txDoneIrq, 1);
        rd(AD_ST); chk("txFlag", rdat[6], 1);
        wr(AD_ST, 8'h40);
        repeat (2) @(posedge clk);
        chk("txIrqClr", irqOut.txDoneIrq, 0);
        pend <= 1;
        repeat (2) @(posedge clk);
        wr(AD_B, 8'h00);
        repeat (3) @(posedge clk);
        chk("txDrain", cfgOut.txPinOwn, 1);
        pend <= 0;
        repeat (3) @(posedge clk);
        chk("txRelease", cfgOut.txPinOwn, 0);
        end_sim();
    end
endmodule
